// >>> src/dual_wiper_serial_control.sv
/*
 Two-wire serial slave that sets two 256-tap wiper positions.
 Assumes an external pull-up on the data wire and a master that clocks
 slowly compared with CLK (clock period well above four CLK periods).
*/
`timescale 1ns/1ps
`default_nettype none
`include "wiper_defines.svh"
module dual_wiper_serial_control (
	// Clock and reset
	input wire logic CLK,
	input wire logic RSTN,
	// Serial link pins
	input wire logic SCL_IN,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE,
	// Straps and protect
	input wire logic ADDR_STRAP_BIT0,
	input wire logic ADDR_STRAP_BIT1,
	input wire logic ADDR_STRAP_BIT2,
	input wire logic WRITE_PROTECT,
	// Wiper positions and status
	output wiper_pkg::tap_t WIPER_A,
	output wiper_pkg::tap_t WIPER_B,
	output logic INIT_DONE
);
	import wiper_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisation

	logic [5:0] sync_vec;
	logic scl_s;
	logic sda_s;
	logic protect_s;
	logic [2:0] strap_s;

	pin_sync #(.WIDTH(6)) u_sync (
		.CLK(CLK),
		.RSTN(RSTN),
		.pin_in({SCL_IN, SDA_IN, WRITE_PROTECT, ADDR_STRAP_BIT2, ADDR_STRAP_BIT1,
			ADDR_STRAP_BIT0}),
		.pin_out(sync_vec)
	);

	assign scl_s = sync_vec[`SYNC_SCL];
	assign sda_s = sync_vec[`SYNC_SDA];
	// Sync resets high, so an open protect pin reads as protected
	assign protect_s = sync_vec[`SYNC_PROTECT];
	assign strap_s = sync_vec[`SYNC_STRAP_HI:`SYNC_STRAP_LO];

	logic scl_q;
	logic sda_q;

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_s;
			sda_q <= sda_s;
		end
	end

	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;

	assign scl_rise = scl_s && !scl_q;
	assign scl_fall = !scl_s && scl_q;
	assign start_det = scl_s && scl_q && sda_q && !sda_s;
	assign stop_det = scl_s && scl_q && !sda_q && sda_s;

	////////////////////////////////////////////////////////////////////////
	// Power-up load timer

	localparam int INIT_CNT = `INIT_CYCLES;
	localparam int INIT_W = $clog2(INIT_CNT + 1);

	logic [INIT_W-1:0] init_cnt_q;
	logic init_done_q;

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			init_cnt_q <= '0;
			init_done_q <= 1'b0;
		end else if (!init_done_q) begin
			init_cnt_q <= init_cnt_q + 1'b1;
			// Load happens on the first cycle; the flag marks the period end
			if (init_cnt_q == INIT_W'(INIT_CNT - 1)) begin
				init_done_q <= 1'b1;
			end
		end
	end

	logic init_load;
	assign init_load = !init_done_q && (init_cnt_q == '0);
	assign INIT_DONE = init_done_q;

	////////////////////////////////////////////////////////////////////////
	// Serial receive state machine

	link_state_t state_q;
	link_state_t after_ack_q;
	logic [2:0] bit_cnt_q;
	logic [7:0] shift_q;
	logic ack_drive_q;
	logic ack_seen_rise_q;
	command_t cmd_q;
	logic [7:0] data_q;
	logic commit_q;

	logic [7:0] shift_next;
	logic [6:0] own_addr;

	assign shift_next = {shift_q[6:0], sda_s};
	assign own_addr = {`ADDR_FIXED_NIBBLE, strap_s};

	logic in_byte;
	logic byte_done;
	logic addr_hit;
	logic ack_take;
	logic ack_seen;
	logic ack_end;

	assign in_byte = (state_q == ST_ADDR) || (state_q == ST_CMD) || (state_q == ST_DATA);
	assign byte_done = in_byte && scl_rise && (bit_cnt_q == `LAST_BIT_IDX);
	// Write-only: a read or no-op flag is not acknowledged
	assign addr_hit = (shift_next[`ADDR_HI:`ADDR_LO] == own_addr)
		&& !shift_next[`ADDR_FLAG_BIT];
	// Pull low after the eighth falling edge, release after the ninth
	assign ack_take = (state_q == ST_ACK) && scl_fall && !ack_drive_q && !ack_seen_rise_q;
	assign ack_seen = (state_q == ST_ACK) && scl_rise && ack_drive_q;
	assign ack_end = (state_q == ST_ACK) && scl_fall && ack_seen_rise_q;

	// Transaction state; START and STOP override every bit and ack phase
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			state_q <= ST_IDLE;
			after_ack_q <= ST_IDLE;
		end else if (start_det) begin
			// Repeated START drops any partial transaction
			state_q <= ST_ADDR;
		end else if (stop_det) begin
			state_q <= ST_IDLE;
		end else begin
			case (state_q)
				ST_IDLE, ST_IGNORE: begin
					// Only a START leaves ST_IDLE; a START or a STOP leaves ST_IGNORE
					state_q <= state_q;
				end
				ST_ADDR: begin
					if (byte_done) begin
						state_q <= addr_hit ? ST_ACK : ST_IGNORE;
						after_ack_q <= ST_CMD;
					end
				end
				ST_CMD: begin
					if (byte_done) begin
						state_q <= ST_ACK;
						after_ack_q <= ST_DATA;
					end
				end
				ST_DATA: begin
					if (byte_done) begin
						state_q <= ST_ACK;
						after_ack_q <= ST_IGNORE;
					end
				end
				ST_ACK: begin
					if (ack_end) begin
						state_q <= after_ack_q;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			bit_cnt_q <= `BIT_CNT_ZERO;
			shift_q <= 8'h00;
		end else if (start_det || ack_end) begin
			bit_cnt_q <= `BIT_CNT_ZERO;
		end else if (in_byte && scl_rise) begin
			shift_q <= shift_next;
			bit_cnt_q <= bit_cnt_q + 3'h1;
		end
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			ack_drive_q <= 1'b0;
			ack_seen_rise_q <= 1'b0;
		end else if (start_det || stop_det) begin
			ack_drive_q <= 1'b0;
		end else if (byte_done) begin
			ack_seen_rise_q <= 1'b0;
		end else if (ack_take) begin
			ack_drive_q <= 1'b1;
		end else if (ack_seen) begin
			ack_seen_rise_q <= 1'b1;
		end else if (ack_end || state_q != ST_ACK) begin
			ack_drive_q <= 1'b0;
		end
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			cmd_q <= '0;
			data_q <= 8'h00;
		end else if (byte_done && state_q == ST_CMD) begin
			cmd_q <= '{op: shift_next[`CMD_OP_HI:`CMD_OP_LO],
				sel: shift_next[`CMD_SEL_HI:`CMD_SEL_LO]};
		end else if (byte_done && state_q == ST_DATA) begin
			data_q <= shift_next;
		end
	end

	// Commit only once the data byte is acknowledged
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			commit_q <= 1'b0;
		end else begin
			commit_q <= ack_end && (after_ack_q == ST_IGNORE);
		end
	end

	// Open drain: only ever pull low, never drive high
	assign SDA_OUT = 1'b0;
	assign SDA_OE = ack_drive_q;

	////////////////////////////////////////////////////////////////////////
	// Command execution

	wiper_pair_t live_q;
	wiper_pair_t saved;
	logic [1:0] saved_wr;
	wiper_pair_t saved_wr_data;
	logic [1:0] live_wr;
	logic [1:0] recall;
	logic is_live;
	logic is_saved;
	logic is_recall;
	logic is_store;

	assign is_live = commit_q && cmd_q.op == `OP_LIVE_WRITE;
	assign is_saved = commit_q && cmd_q.op == `OP_SAVED_WRITE;
	assign is_recall = commit_q && cmd_q.op == `OP_RECALL;
	assign is_store = commit_q && cmd_q.op == `OP_STORE;

	always_comb begin
		saved_wr = 2'h0;
		saved_wr_data = '{a: data_q, b: data_q};
		if (is_saved) begin
			saved_wr = cmd_q.sel;
		end else if (is_store) begin
			saved_wr = cmd_q.sel;
			saved_wr_data = live_q;
		end
	end

	assign live_wr = (is_live && !protect_s) ? cmd_q.sel : 2'h0;
	assign recall = is_recall ? cmd_q.sel : 2'h0;

	saved_store u_store (
		.CLK(CLK),
		.RSTN(RSTN),
		.protect(protect_s),
		.wr_en(saved_wr),
		.wr_data(saved_wr_data),
		.saved(saved)
	);

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			live_q <= '0;
		end else if (init_load) begin
			live_q <= saved;
		end else begin
			if (recall[`SEL_A_BIT]) begin
				live_q.a <= saved.a;
			end else if (live_wr[`SEL_A_BIT]) begin
				live_q.a <= data_q;
			end
			if (recall[`SEL_B_BIT]) begin
				live_q.b <= saved.b;
			end else if (live_wr[`SEL_B_BIT]) begin
				live_q.b <= data_q;
			end
		end
	end

	// Eight-bit register gives exactly 256 positions
	assign WIPER_A = live_q.a;
	assign WIPER_B = live_q.b;

endmodule : dual_wiper_serial_control
`default_nettype wire

// >>> src/wiper_defines.svh
/*
 Constants for the dual wiper serial control slave: address pattern, command
 field positions and codes, timing figures. Assumes a 50 MHz system clock.
*/
// Notes on behaviour
// - Each of two wipers takes one of 256 positions from an eight-bit value.
// - After reset, saved values are copied into the live wiper registers.
// - A value accepted into a live register drives the wiper output at once.
// - Write-protect high or open refuses every write to saved storage.
// - Write-protect high lets the live register change only by recall.
// - Write-protect low allows saved writes, recall and direct live writes.
// - Slave address upper four bits are fixed at 0101.
// - Low three address bits equal the three strap pins, bit two first.
// - Eighth address bit low means write; high means no operation.
// - START is data falling with clock high; STOP is data rising, clock high.
// - Clock and data both stay high while the bus is idle.
// - One bit per clock pulse; data changes only while clock is low.
// - Receiver holds data low during the ninth clock pulse to acknowledge.
// - Clock is input only; data is driven only as open drain.
// - First byte after write address is command; next byte goes where it says.
// - Command picks live or saved target, or orders a copy between them.
// - Live write stores data in the live register and moves the wiper.
// - Saved write stores data only in storage; wiper stays put.
// - Bits 6..4 pick operation 001/010/110/101; bits 1..0 pick A, B or both.
// - Recall copies the saved value into the live register.
// - Store copies the present live value into saved storage.
// - Power-up load completes within ten microseconds.
`ifndef WIPER_DEFINES_SVH
`define WIPER_DEFINES_SVH

`define ADDR_FIXED_NIBBLE 4'h5
`define CMD_OP_HI 6
`define CMD_OP_LO 4
`define CMD_SEL_HI 1
`define CMD_SEL_LO 0
`define OP_LIVE_WRITE 3'h1
`define OP_SAVED_WRITE 3'h2
`define OP_RECALL 3'h6
`define OP_STORE 3'h5
`define SEL_A_BIT 0
`define SEL_B_BIT 1
`define SAVED_RESET 8'h80
`define CLK_MHZ 50
`define INIT_TIME_NS 10000
`define INIT_CYCLES ((`INIT_TIME_NS * `CLK_MHZ) / 1000)
`define LAST_BIT_IDX 3'h7
`define BIT_CNT_ZERO 3'h0
`define ADDR_HI 7
`define ADDR_LO 1
`define ADDR_FLAG_BIT 0
`define SYNC_SCL 5
`define SYNC_SDA 4
`define SYNC_PROTECT 3
`define SYNC_STRAP_HI 2
`define SYNC_STRAP_LO 0

`endif

// >>> src/wiper_pkg.sv
/*
 Types shared by the wiper control slave and its helpers.
 Assumes the defines header is compiled alongside.
*/
package wiper_pkg;

	typedef logic [7:0] tap_t;

	typedef struct packed {
		logic [2:0] op;
		logic [1:0] sel;
	} command_t;

	typedef struct packed {
		tap_t a;
		tap_t b;
	} wiper_pair_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_CMD,
		ST_DATA,
		ST_ACK,
		ST_IGNORE
	} link_state_t;

endpackage : wiper_pkg

// >>> src/pin_sync.sv
/*
 Two-flop synchroniser for the serial pins, one per bit by generate loop.
 Assumes the inputs are asynchronous to CLK; the outputs reset high (idle).
*/
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter int WIDTH = 2
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RSTN,
	// Pins in, synchronised out
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] pin_out
);
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			logic meta_q;
			logic sync_q;
			always_ff @(posedge CLK or negedge RSTN) begin
				if (!RSTN) begin
					meta_q <= 1'b1;
					sync_q <= 1'b1;
				end else begin
					meta_q <= pin_in[i];
					sync_q <= meta_q;
				end
			end
			assign pin_out[i] = sync_q;
		end
	endgenerate
endmodule : pin_sync
`default_nettype wire

// >>> src/saved_store.sv
/*
 Saved (nonvolatile-like) storage for both wipers. Writes land only while
 the protect input is low. Assumes write strobes are one-cycle pulses.
*/
`timescale 1ns/1ps
`default_nettype none
`include "wiper_defines.svh"
module saved_store (
	// Clock and reset
	input wire logic CLK,
	input wire logic RSTN,
	// Control
	input wire logic protect,
	input wire logic [1:0] wr_en,
	input wire wiper_pkg::wiper_pair_t wr_data,
	// Contents
	output wiper_pkg::wiper_pair_t saved
);
	import wiper_pkg::*;

	// Reset value stands in for the factory-programmed midscale
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			saved <= '{a: `SAVED_RESET, b: `SAVED_RESET};
		end else if (!protect) begin
			if (wr_en[`SEL_A_BIT]) begin
				saved.a <= wr_data.a;
			end
			if (wr_en[`SEL_B_BIT]) begin
				saved.b <= wr_data.b;
			end
		end
	end
endmodule : saved_store
`default_nettype wire

// >>> verification/wiper_serial_checker.sv
/*
 Port assertions for the dual wiper serial slave.
 Assumes a master clock half period of at least four CLK periods.
*/
`timescale 1ns/1ps
`default_nettype none
`include "wiper_defines.svh"
module wiper_serial_checker (
	// Clock and reset
	input wire logic CLK,
	input wire logic RSTN,
	// Link, straps and protect
	input wire logic SCL_IN,
	input wire logic SDA_IN,
	input wire logic SDA_OUT,
	input wire logic SDA_OE,
	input wire logic ADDR_STRAP_BIT0,
	input wire logic ADDR_STRAP_BIT1,
	input wire logic ADDR_STRAP_BIT2,
	input wire logic WRITE_PROTECT,
	// Wipers and status
	input wire wiper_pkg::tap_t WIPER_A,
	input wire wiper_pkg::tap_t WIPER_B,
	input wire logic INIT_DONE
);
	import wiper_pkg::*;
	logic [9:0] cyc_q;
	logic [2:0] oe_gap_q;
	logic [2:0] fall_gap_q;
	logic scl_q;
	logic sda_q;
	logic idle_q;
	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) cyc_q <= 10'h0;
		else if (cyc_q != 10'h3ff) cyc_q <= cyc_q + 10'h1;
	end
	// Gaps saturate so long idle stretches never wrap
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			oe_gap_q <= 3'h7;
			fall_gap_q <= 3'h7;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			idle_q <= 1'b1;
		end else begin
			scl_q <= SCL_IN;
			sda_q <= SDA_IN;
			// Bus is idle from a STOP until the next START
			if (scl_q && SCL_IN && !sda_q && SDA_IN) begin
				idle_q <= 1'b1;
			end else if (scl_q && SCL_IN && sda_q && !SDA_IN) begin
				idle_q <= 1'b0;
			end
			oe_gap_q <= SDA_OE ? 3'h0 : (oe_gap_q == 3'h7 ? oe_gap_q : oe_gap_q + 3'h1);
			fall_gap_q <= (scl_q && !SCL_IN) ? 3'h0 :
				(fall_gap_q == 3'h7 ? fall_gap_q : fall_gap_q + 3'h1);
		end
	end
	////////////////////////////////////////////////////////////////////////
	default clocking @(posedge CLK); endclocking
	default disable iff (!RSTN);
	AST_OPEN_DRAIN: assert property (SDA_OUT == 1'b0)
		else $error("data wire driven high");
	AST_INIT_LOAD: assert property (cyc_q == 10'h3 |->
		WIPER_A == `SAVED_RESET && WIPER_B == `SAVED_RESET)
		else $error("wipers not loaded from saved values");
	AST_INIT_TIME: assert property ($rose(INIT_DONE) |-> cyc_q >= 10'h1ef && cyc_q <= 10'h1f6)
		else $error("init period length off");
	AST_ACK_HOLD: assert property ($rose(SCL_IN) && SDA_OE |=> SDA_OE [*3])
		else $error("ack released in clock high phase");
	AST_IDLE_RELEASE: assert property (idle_q |-> !SDA_OE)
		else $error("data pulled while bus idle");
	AST_WIPER_CAUSE: assert property (INIT_DONE && ($changed(WIPER_A) || $changed(WIPER_B))
		|-> oe_gap_q <= 3'h5)
		else $error("wiper moved without a finished transfer");
	AST_ACK_RISE: assert property ($rose(SDA_OE) |-> fall_gap_q <= 3'h5)
		else $error("ack started away from a clock fall");
	AST_ACK_FALL: assert property ($fell(SDA_OE) |-> fall_gap_q <= 3'h5)
		else $error("ack ended away from a clock fall");
	CVR_ACK: cover property ($rose(SDA_OE));
	CVR_WIPER_A: cover property (INIT_DONE && $changed(WIPER_A));
	CVR_INIT: cover property ($rose(INIT_DONE));
endmodule : wiper_serial_checker
bind dual_wiper_serial_control wiper_serial_checker u_chk (.CLK(CLK), .RSTN(RSTN),
	.SCL_IN(SCL_IN), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
	.ADDR_STRAP_BIT0(ADDR_STRAP_BIT0), .ADDR_STRAP_BIT1(ADDR_STRAP_BIT1),
	.ADDR_STRAP_BIT2(ADDR_STRAP_BIT2), .WRITE_PROTECT(WRITE_PROTECT),
	.WIPER_A(WIPER_A), .WIPER_B(WIPER_B), .INIT_DONE(INIT_DONE));
`default_nettype wire

// >>> verification/serial_master_model.sv
/*
 Behavioural two-wire bus master, 160 ns bit clock.
 Assumes a pull-up on the data wire; clock driven push-pull.
*/
`timescale 1ns/1ps
`default_nettype none
module serial_master_model (
	// Bus
	output logic scl,
	output logic sda_low,
	input wire logic sda
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic pulse(input logic b, output logic ack);
		#40 sda_low = !b;
		#40 scl = 1'b1;
		#40 ack = !sda;
		#40 scl = 1'b0;
	endtask : pulse
	// Stops after nb bytes, so a short count aborts the transaction
	task automatic xfer(input logic [23:0] bytes, input int nb, output logic [2:0] acks);
		logic a;
		logic [23:0] s;
		s = bytes;
		acks = 3'h0;
		sda_low = 1'b1;
		#80 scl = 1'b0;
		for (int i = 0; i < nb; i++) begin
			for (int j = 0; j < 8; j++) begin
				pulse(s[23], a);
				s = s << 1;
			end
			pulse(1'b1, a);
			acks[2 - i] = a;
		end
		#40 sda_low = 1'b1;
		#40 scl = 1'b1;
		#40 sda_low = 1'b0;
		#80;
	endtask : xfer
endmodule : serial_master_model
`default_nettype wire

// >>> verification/test_dual_wiper_serial_control.sv
/*
 Self-checking bench for the dual wiper slave with random and corner cases.
 Assumes the master model above and a pull-up on the data wire.
*/
`timescale 1ns/1ps
`default_nettype none
`include "wiper_defines.svh"
module test_dual_wiper_serial_control;
	import wiper_pkg::*;
	logic clk, rst_n, wp, scl, m_low, sda, oe, sda_out, init_done;
	logic [2:0] strap;
	tap_t wa, wb;
	wiper_pair_t live, sav;
	int fails, checked;
	assign sda = !(oe || m_low);
	dual_wiper_serial_control u_dut (.CLK(clk), .RSTN(rst_n), .SCL_IN(scl), .SDA_IN(sda),
		.SDA_OUT(sda_out), .SDA_OE(oe), .ADDR_STRAP_BIT0(strap[0]),
		.ADDR_STRAP_BIT1(strap[1]), .ADDR_STRAP_BIT2(strap[2]), .WRITE_PROTECT(wp),
		.WIPER_A(wa), .WIPER_B(wb), .INIT_DONE(init_done));
	serial_master_model u_master (.scl(scl), .sda_low(m_low), .sda(sda));
	initial begin
		clk = 1'b0;
		forever #10 clk = !clk;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : report_and_stop
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	function automatic wiper_pair_t pick(wiper_pair_t cur, wiper_pair_t src, logic [1:0] sel);
		pick = cur;
		if (sel[`SEL_A_BIT]) pick.a = src.a;
		if (sel[`SEL_B_BIT]) pick.b = src.b;
	endfunction : pick
	// Mode 0 full write, 1 wrong address, 2 no-op flag, 3 stop after command
	task automatic run(input logic [2:0] op, input logic [1:0] sel, input int mode);
		logic [2:0] acks;
		logic [6:0] adr;
		tap_t d;
		@(posedge clk);
		#1;
		wp = 1'($urandom);
		strap = 3'($urandom);
		d = 8'($urandom);
		adr = {`ADDR_FIXED_NIBBLE, strap};
		if (mode == 1) adr = adr ^ 7'(7'h1 << ($urandom % 7));
		u_master.xfer({adr, mode == 2, 1'b0, op, 2'b00, sel, d}, mode == 3 ? 2 : 3, acks);
		check(16'(acks), mode == 0 ? 16'h7 : (mode == 3 ? 16'h6 : 16'h0));
		if (mode == 0) begin
			case (op)
				`OP_LIVE_WRITE: if (!wp) live = pick(live, {d, d}, sel);
				`OP_SAVED_WRITE: if (!wp) sav = pick(sav, {d, d}, sel);
				`OP_RECALL: live = pick(live, sav, sel);
				`OP_STORE: if (!wp) sav = pick(sav, live, sel);
				default: ;
			endcase
		end
		check({wa, wb}, live);
		check(16'(sda_out), 16'h0);
	endtask : run
	////////////////////////////////////////////////////////////////////////
	initial begin
		int n;
		rst_n = 1'b0;
		wp = 1'b1;
		strap = 3'h0;
		live = {`SAVED_RESET, `SAVED_RESET};
		sav = live;
		fails = 0;
		checked = 0;
		void'($urandom(13595));
		repeat (8) @(posedge clk);
		#1 rst_n = 1'b1;
		for (n = 0; n < 600 && init_done !== 1'b1; n++) begin
			@(posedge clk);
			#1;
		end
		check(16'(n >= 495 && n <= 505), 16'h1);
		// A timed-out init already counted a mismatch; skip straight to the verdict
		if (n < 600) begin
			check({wa, wb}, live);
			for (int o = 0; o < 8; o++) begin
				for (int s = 0; s < 4; s++) run(3'(o), 2'(s), 0);
			end
			for (int k = 0; k < 9; k++) run(`OP_LIVE_WRITE, 2'h3, 1 + k % 3);
			repeat (30) run(3'($urandom), 2'($urandom), 0);
		end
		report_and_stop();
	end
endmodule : test_dual_wiper_serial_control
`default_nettype wire
